// *** design/ctc_pkg.sv ***
// Package of constants for the capture timer with AXI4-Lite registers
package ctc_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    // Alias locations are word indices; byte address is four times the index
    localparam int CTC_CTL1_T0_IDX = 32'h0000_0F07;
    localparam int CTC_CTL1_T1_IDX = 32'h0000_0F0F;
    localparam logic [13:0] CTC_CTL1_T0_ADDR = 14'(CTC_CTL1_T0_IDX * 4);
    localparam logic [13:0] CTC_CTL1_T1_ADDR = 14'(CTC_CTL1_T1_IDX * 4);
    localparam int CTC_CTL1_IDX = 0;
    localparam logic [13:0] CTC_CTL0_ADDR = 14'h0000;
    localparam logic [13:0] CTC_CTL1_ADDR = 14'h0004;
    localparam logic [13:0] CTC_CNT_ADDR = 14'h0008;
    localparam logic [13:0] CTC_RLD_ADDR = 14'h000C;
    localparam logic [13:0] CTC_CAP_ADDR = 14'h0010;
    localparam logic [13:0] CTC_STAT_ADDR = 14'h0014;
    localparam logic [13:0] CTC_MASK_ADDR = 14'h0018;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTC_EN_BIT = 7;
    localparam int CTC_POL_BIT = 6;
    localparam int CTC_CAUSE_BIT = 0;
    localparam logic [7:0] CTC_CTL0_RST = 8'h00;
    localparam logic [7:0] CTC_CTL1_RST = 8'h00;
    localparam logic [15:0] CTC_CNT_RST = 16'h0001;
    localparam logic [15:0] CTC_RLD_RST = 16'hFFFF;
    localparam logic [1:0] CTC_SRC_ALL_HI = 2'h0;
    localparam logic [1:0] CTC_SRC_INPUT = 2'h2;
    localparam logic [1:0] CTC_SRC_RELOAD = 2'h3;
    localparam logic [2:0] CTC_MODE_CAPTURE = 3'h4;

    // ****************************************
    // Status bits and bus answers
    // ****************************************
    localparam int CTC_ST_RELOAD = 0;
    localparam int CTC_ST_CAPTURE = 1;
    localparam logic [1:0] CTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] CTC_RESP_SLVERR = 2'h2;
    localparam logic [7:0] CTC_DLY_ONE = 8'h01;

endpackage

// *** design/ctc_top.sv ***
// Capture timer with reload, delay field and AXI4-Lite register slave
`timescale 1ns/10ps
module ctc_top
    import ctc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pins and interrupts
    input wire logic timer_in,
    output logic timer_out,
    output logic timer_out_n,
    output logic irq_pulse,
    output logic irq_level
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic aw_have;
        logic [13:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] rld;
        logic [CNT_W-1:0] cap;
        logic [6:0] pre;
        logic in_q;
        logic [1:0] stat;
        logic [1:0] mask;
        logic irq;
        logic irq_lvl;
        logic tout;
        logic [7:0] dly;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic tout_n;
    } ctc_state_t;

    ctc_state_t s_r;
    ctc_state_t s_nxt;

    logic [6:0] pre_lim;
    logic tick;
    logic edge_hit;
    logic rld_hit;
    logic wr_go;
    logic [31:0] wr_word;
    logic [7:0] dly_cyc;

    // Prescale divides by 2**field
    assign pre_lim = 7'((8'h01 << s_r.ctl1[5:3]) - 8'h01);
    assign tick = s_r.ctl1[CTC_EN_BIT] && (s_r.pre == pre_lim);
    assign edge_hit = s_r.ctl1[CTC_EN_BIT] && (s_r.ctl1[2:0] == CTC_MODE_CAPTURE) &&
        (s_r.ctl1[CTC_POL_BIT] ? (!s_r.in_q && timer_in)
                               : (s_r.in_q && !timer_in));
    assign rld_hit = tick && (s_r.cnt == s_r.rld);
    assign wr_go = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    // Delay code n gives 2**n cycles, code 0 none
    assign dly_cyc = (s_r.ctl0[3:1] == 3'h0) ? 8'h00
                   : 8'(CTC_DLY_ONE << s_r.ctl0[3:1]);

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            wr_word[i] = s_r.w_strb[i / 8] ? s_r.w_data[i] : 1'b0;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic src_ok_cap;
        logic src_ok_rld;
        logic [13:0] ra;
        src_ok_cap = 1'b0;
        src_ok_rld = 1'b0;
        ra = s_axi_araddr;
        s_nxt = s_r;
        s_nxt.irq = 1'b0;
        s_nxt.in_q = timer_in;
        src_ok_cap = (s_r.ctl0[6:5] != CTC_SRC_RELOAD);
        src_ok_rld = (s_r.ctl0[6:5] != CTC_SRC_INPUT);

        // Counter and prescaler
        if (!s_r.ctl1[CTC_EN_BIT]) begin
            s_nxt.pre = 7'h00;
        end else if (tick) begin
            s_nxt.pre = 7'h00;
            s_nxt.cnt = rld_hit ? CNT_W'(1) : s_r.cnt + CNT_W'(1);
        end else begin
            s_nxt.pre = s_r.pre + 7'h01;
        end
        if (rld_hit) begin
            s_nxt.stat[CTC_ST_RELOAD] = 1'b1;
            if (src_ok_rld) begin
                s_nxt.irq = 1'b1;
                s_nxt.ctl0[CTC_CAUSE_BIT] = 1'b0;
            end
        end
        if (edge_hit) begin
            s_nxt.cap = s_r.cnt;
            s_nxt.stat[CTC_ST_CAPTURE] = 1'b1;
            if (src_ok_cap) begin
                s_nxt.irq = 1'b1;
                s_nxt.ctl0[CTC_CAUSE_BIT] = 1'b1;
            end
        end

        // Delayed output assertion while enabled
        if (!s_r.ctl1[CTC_EN_BIT]) begin
            s_nxt.dly = 8'h00;
            s_nxt.tout = 1'b0;
        end else if (s_r.dly < dly_cyc) begin
            s_nxt.dly = s_r.dly + 8'h01;
        end else begin
            s_nxt.tout = 1'b1;
        end

        // Write channel capture
        if (s_axi_awvalid && !s_r.aw_have) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_have) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = CTC_RESP_OKAY;
            unique case (s_r.aw_addr)
                CTC_CTL0_ADDR: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.ctl0[6:1] = {s_r.w_data[6:5], 1'b0, s_r.w_data[3:1]};
                    end
                end
                CTC_CTL1_ADDR, CTC_CTL1_T0_ADDR, CTC_CTL1_T1_ADDR: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.ctl1 = s_r.w_data[7:0];
                    end
                end
                CTC_CNT_ADDR: s_nxt.cnt = wr_word[CNT_W-1:0] | (s_r.cnt & ~CNT_W'(
                    {{8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}}));
                CTC_RLD_ADDR: s_nxt.rld = wr_word[CNT_W-1:0] | (s_r.rld & ~CNT_W'(
                    {{8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}}));
                CTC_CAP_ADDR: s_nxt.cap = wr_word[CNT_W-1:0] | (s_r.cap & ~CNT_W'(
                    {{8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}}));
                CTC_STAT_ADDR: begin
                    // Set wins over write-one-to-clear
                    s_nxt.stat = (s_r.stat & ~wr_word[1:0]) |
                        {edge_hit, rld_hit};
                end
                CTC_MASK_ADDR: s_nxt.mask = wr_word[1:0];
                default: s_nxt.bresp = CTC_RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Read channel
        if (s_axi_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = CTC_RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            unique case (ra)
                CTC_CTL0_ADDR: s_nxt.rdata[7:0] = s_r.ctl0;
                CTC_CTL1_ADDR, CTC_CTL1_T0_ADDR, CTC_CTL1_T1_ADDR:
                    s_nxt.rdata[7:0] = s_r.ctl1;
                CTC_CNT_ADDR: s_nxt.rdata[CNT_W-1:0] = s_r.cnt;
                CTC_RLD_ADDR: s_nxt.rdata[CNT_W-1:0] = s_r.rld;
                CTC_CAP_ADDR: s_nxt.rdata[CNT_W-1:0] = s_r.cap;
                CTC_STAT_ADDR: s_nxt.rdata[1:0] = s_r.stat;
                CTC_MASK_ADDR: s_nxt.rdata[1:0] = s_r.mask;
                default: s_nxt.rresp = CTC_RESP_SLVERR;
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.irq_lvl = |(s_nxt.stat & s_nxt.mask);
        // Ready and complement outputs leave flops directly
        s_nxt.aw_rdy = !s_nxt.aw_have;
        s_nxt.w_rdy = !s_nxt.w_have;
        s_nxt.ar_rdy = !s_nxt.rvalid;
        s_nxt.tout_n = !s_nxt.tout;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.ctl0 <= CTC_CTL0_RST;
            s_r.ctl1 <= CTC_CTL1_RST;
            s_r.cnt <= CTC_CNT_RST;
            s_r.rld <= CTC_RLD_RST;
            s_r.aw_rdy <= 1'b1;
            s_r.w_rdy <= 1'b1;
            s_r.ar_rdy <= 1'b1;
            s_r.tout_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = s_r.aw_rdy;
    assign s_axi_wready = s_r.w_rdy;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.ar_rdy;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign timer_out = s_r.tout;
    assign timer_out_n = s_r.tout_n;
    assign irq_pulse = s_r.irq;
    assign irq_level = s_r.irq_lvl;

    // ****************************************
    // Checks
    // ****************************************
    chk_reload_wraps: assert property (@(posedge aclk) disable iff (!aresetn)
        (rld_hit && !wr_go) |=> s_r.cnt == CNT_W'(1))
        else $error("counter did not restart after reload");
    chk_reload_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        (rld_hit && !edge_hit && s_r.ctl0[6:5] != CTC_SRC_INPUT) |=> !s_r.ctl0[0])
        else $error("cause flag not cleared on reload");
    chk_src_input: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_r.ctl0[6:5] == CTC_SRC_INPUT && !edge_hit) |=> !irq_pulse)
        else $error("interrupt without input event");
    chk_src_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_r.ctl0[6:5] == CTC_SRC_RELOAD && !rld_hit) |=> !irq_pulse)
        else $error("interrupt without reload event");
    chk_delay_none: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_r.ctl1[7] && s_r.dly >= dly_cyc) |=> timer_out || !$past(s_r.ctl1[7], 1) ||
        !s_r.ctl1[7])
        else $error("output not asserted after delay");
    chk_cause_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        (edge_hit && s_r.ctl0[6:5] != CTC_SRC_RELOAD) |=> s_r.ctl0[0])
        else $error("cause flag not set on capture");
    chk_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (!s_r.ctl1[7] && !wr_go) |=> $stable(s_r.cnt))
        else $error("counter moved while disabled");
    chk_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_hit |=> s_r.cap == $past(s_r.cnt, 1))
        else $error("capture value wrong");
    chk_irq_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_pulse && !$past(rld_hit, 1) && !$past(edge_hit, 1)) |-> 1'b0)
        else $error("interrupt without cause");

endmodule

// *** dv/ctc_peer.sv ***
// Timer input driver and interrupt controller model
`timescale 1ns/10ps
module ctc_peer (
    // Clock and interrupt
    input wire logic aclk,
    input wire logic irq_pulse,
    // Timer pin
    output logic timer_in
);
    int pulses = 0;
    int long_pulses = 0;
    logic last = 1'h0;
    initial timer_in = 1'h0;
    // ****
    // Request counting
    // ****
    always @(posedge aclk) begin
        if (irq_pulse === 1'h1) pulses++;
        if (irq_pulse === 1'h1 && last === 1'h1) long_pulses++;
        last <= irq_pulse;
    end
    task drive(input logic v);
        @(posedge aclk);
        timer_in <= v;
    endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the capture timer
`timescale 1ns/10ps
module tb_top;
    import ctc_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic timer_in, timer_out, timer_out_n, irq_pulse, irq_level, got;
    int err_total = 0;
    int comparisons = 0;
    int p;
    ctc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_in,
        .timer_out, .timer_out_n, .irq_pulse, .irq_level);
    ctc_peer u_peer (.aclk, .irq_pulse, .timer_in);
    initial forever #2.5 aclk = ~aclk;
    // ****
    // Shared tasks
    // ****
    task results();
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task hang();
        check(32'h0, 32'h1);
        results();
    endtask
    task axw(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                s_axi_bready <= 1'h0;
                check({30'h0, s_axi_bresp}, {30'h0, er});
                done = 1'h1;
            end
        end
        if (!done) hang();
    endtask
    task axr(input logic [13:0] a, input logic [1:0] er, output logic [31:0] d);
        logic done;
        done = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                s_axi_rready <= 1'h0;
                check({30'h0, s_axi_rresp}, {30'h0, er});
                d = s_axi_rdata;
                done = 1'h1;
            end
        end
        if (!done) hang();
    endtask
    task wirq(output logic seen);
        seen = 1'h0;
        for (int n = 0; n < 300 && !seen; n++) begin
            @(posedge aclk);
            seen = (irq_pulse === 1'h1);
        end
    endtask
    // ****
    // Scenarios
    // ****
    task t_regs();
        axr(CTC_CTL1_ADDR, CTC_RESP_OKAY, rd);
        check(rd, 32'h0);
        axw(CTC_CTL1_T0_ADDR, 32'h44, CTC_RESP_OKAY);
        axr(CTC_CTL1_T1_ADDR, CTC_RESP_OKAY, rd);
        check(rd, 32'h44);
        axr(14'h001C, CTC_RESP_SLVERR, rd);
        check(rd, 32'h0);
        axw(CTC_CTL0_ADDR, 32'h0, CTC_RESP_OKAY);
    endtask
    task t_capture();
        axw(CTC_CNT_ADDR, 32'h1, CTC_RESP_OKAY);
        axw(CTC_RLD_ADDR, 32'hFFFF, CTC_RESP_OKAY);
        axw(CTC_MASK_ADDR, 32'h3, CTC_RESP_OKAY);
        axw(CTC_CTL1_ADDR, 32'hC4, CTC_RESP_OKAY);
        u_peer.drive(1'h1);
        wirq(got);
        check({31'h0, got}, 32'h1);
        axr(CTC_CTL0_ADDR, CTC_RESP_OKAY, rd);
        check({31'h0, rd[0]}, 32'h1);
        axr(CTC_CAP_ADDR, CTC_RESP_OKAY, rd);
        check({31'h0, rd > 32'h0 && rd < 32'h40}, 32'h1);
        axw(CTC_STAT_ADDR, 32'h3, CTC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check({31'h0, irq_level}, 32'h0);
        u_peer.drive(1'h0);
        repeat (10) @(posedge aclk);
        axr(CTC_STAT_ADDR, CTC_RESP_OKAY, rd);
        check({31'h0, rd[1]}, 32'h0);
    endtask
    task t_reload();
        axw(CTC_CTL1_ADDR, 32'h44, CTC_RESP_OKAY);
        axw(CTC_CNT_ADDR, 32'h1, CTC_RESP_OKAY);
        axw(CTC_RLD_ADDR, 32'h10, CTC_RESP_OKAY);
        axw(CTC_CAP_ADDR, 32'h0, CTC_RESP_OKAY);
        axw(CTC_CTL1_ADDR, 32'hC4, CTC_RESP_OKAY);
        wirq(got);
        check({31'h0, got}, 32'h1);
        check({31'h0, irq_level}, 32'h1);
        axr(CTC_CAP_ADDR, CTC_RESP_OKAY, rd);
        check(rd, 32'h0);
        axr(CTC_CTL0_ADDR, CTC_RESP_OKAY, rd);
        check({31'h0, rd[0]}, 32'h0);
        axw(CTC_CTL1_ADDR, 32'h44, CTC_RESP_OKAY);
        axw(CTC_STAT_ADDR, 32'h3, CTC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check({31'h0, irq_level}, 32'h0);
        axw(CTC_CNT_ADDR, 32'h3, CTC_RESP_OKAY);
        repeat (20) @(posedge aclk);
        axr(CTC_CNT_ADDR, CTC_RESP_OKAY, rd);
        check(rd, 32'h3);
        axw(CTC_CNT_ADDR, 32'h1, CTC_RESP_OKAY);
        axw(CTC_CTL1_ADDR, 32'h9C, CTC_RESP_OKAY);
        repeat (76) @(posedge aclk);
        axw(CTC_CTL1_ADDR, 32'h1C, CTC_RESP_OKAY);
        axr(CTC_CNT_ADDR, CTC_RESP_OKAY, rd);
        check({31'h0, rd >= 32'hA && rd <= 32'hC}, 32'h1);
    endtask
    task t_source();
        axw(CTC_CTL0_ADDR, 32'h40, CTC_RESP_OKAY);
        axw(CTC_CTL1_ADDR, 32'h84, CTC_RESP_OKAY);
        p = u_peer.pulses;
        repeat (40) @(posedge aclk);
        check(32'(u_peer.pulses - p), 32'h0);
        u_peer.drive(1'h1);
        u_peer.drive(1'h0);
        wirq(got);
        check({31'h0, got}, 32'h1);
        axw(CTC_CTL0_ADDR, 32'h60, CTC_RESP_OKAY);
        wirq(got);
        check({31'h0, got}, 32'h1);
        axr(CTC_CTL0_ADDR, CTC_RESP_OKAY, rd);
        check(rd, 32'h60);
        axw(CTC_CTL1_ADDR, 32'h04, CTC_RESP_OKAY);
    endtask
    task t_delay();
        int n;
        axw(CTC_CTL0_ADDR, 32'h0E, CTC_RESP_OKAY);
        axw(CTC_CTL1_ADDR, 32'h84, CTC_RESP_OKAY);
        check({31'h0, timer_out}, 32'h0);
        for (n = 0; n < 300 && timer_out !== 1'h1; n++) @(posedge aclk);
        check({31'h0, n >= 120 && n <= 130}, 32'h1);
        check({31'h0, timer_out_n}, 32'h0);
        check(32'(u_peer.long_pulses), 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_capture();
        t_reload();
        t_source();
        t_delay();
        results();
    end
endmodule
